// *** core/fbp_pkg.sv ***
package fbp_pkg;

	// ------------------------------------------------------------
	// Widths and timing
	// ------------------------------------------------------------
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	localparam int PWD_W = 64;
	localparam int BLOCK_LSB = 16;
	localparam int CLK_PERIOD_NS = 50;
	localparam int PWD_DELAY_NS = 6000;
	localparam int PWD_DELAY_CYC = (PWD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WE_LOW_NS = 50;
	localparam int WE_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_ACCESS_NS = 110;
	localparam int RD_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Bus addresses and codes
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 26'h0000555;
	localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 26'h00002AA;
	localparam logic [ADDR_W-1:0] ADDR_ANY = 26'h0000000;
	localparam logic [7:0] CODE_AA = 8'hAA;
	localparam logic [7:0] CODE_55 = 8'h55;
	localparam logic [7:0] CODE_PROG = 8'hA0;
	localparam logic [7:0] CODE_EXIT1 = 8'h90;
	localparam logic [7:0] CODE_EXIT2 = 8'h00;
	localparam logic [7:0] CODE_CLR1 = 8'h80;
	localparam logic [7:0] CODE_CLR2 = 8'h30;
	localparam logic [7:0] CODE_UNL1 = 8'h25;
	localparam logic [7:0] CODE_UNL2 = 8'h03;
	localparam logic [7:0] CODE_UNL3 = 8'h29;
	localparam logic [15:0] PROT_ON = 16'h0000;
	localparam logic [15:0] PROT_OFF = 16'h0001;

	// Mode codes double as the entry codes
	localparam logic [7:0] MODE_READ = 8'h00;
	localparam logic [7:0] MODE_LOCKREG = 8'h40;
	localparam logic [7:0] MODE_PWD = 8'h60;
	localparam logic [7:0] MODE_NV = 8'hC0;
	localparam logic [7:0] MODE_LOCKBIT = 8'h50;
	localparam logic [7:0] MODE_VOL = 8'hE0;
	localparam logic [7:0] MODE_EXT = 8'h88;

	typedef enum logic [3:0] {
		OP_ENTER = 4'h0,
		OP_EXIT = 4'h1,
		OP_READ = 4'h2,
		OP_PROG = 4'h3,
		OP_PROTECT = 4'h4,
		OP_UNPROTECT = 4'h5,
		OP_CLEAR_ALL = 4'h6,
		OP_UNLOCK = 4'h7,
		OP_READ_PWD = 4'h8
	} fbp_op_t;

endpackage

// *** core/fbp_bus_cycle.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbp_bus_cycle
	import fbp_pkg::*;
#(
	parameter int WE_CYCLES = WE_CYC,
	parameter int RD_CYCLES = RD_CYC
) (
	// System
	input wire logic mclk,
	input wire logic rst,
	// Cycle request
	input wire logic start,
	input wire logic isRead,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	output logic done,
	output logic [DATA_W-1:0] rdata,
	// Flash pins
	output logic flashCeN,
	output logic flashOeN,
	output logic flashWeN,
	output logic [ADDR_W-1:0] flashAddr,
	output logic [DATA_W-1:0] flashDqOut,
	output logic flashDqOe,
	input wire logic [DATA_W-1:0] flashDqIn
);

	// ------------------------------------------------------------
	// Cycle sequencer
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		C_IDLE = 2'b00,
		C_SETUP = 2'b01,
		C_STROBE = 2'b10,
		C_HOLD = 2'b11
	} fbp_cyc_t;

	fbp_cyc_t state_reg, state_next;
	logic [3:0] cnt_reg;
	logic rd_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] wdata_reg;

	wire logic [3:0] strobeLen = rd_reg ? 4'(RD_CYCLES) : 4'(WE_CYCLES);
	wire logic strobeEnd = (state_reg == C_STROBE) && (cnt_reg == strobeLen - 4'h1);

	always_comb begin
		case (state_reg)
			C_IDLE: state_next = start ? C_SETUP : C_IDLE;
			C_SETUP: state_next = C_STROBE;
			C_STROBE: state_next = strobeEnd ? C_HOLD : C_STROBE;
			C_HOLD: state_next = C_IDLE;
			default: state_next = C_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= C_IDLE;
			cnt_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= (state_reg == C_STROBE && !strobeEnd) ? cnt_reg + 4'h1 : 4'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_reg <= 1'b0;
			addr_reg <= '0;
			wdata_reg <= '0;
			rdata_reg <= '0;
		end else begin
			if (state_reg == C_IDLE && start) begin
				rd_reg <= isRead;
				addr_reg <= addr;
				wdata_reg <= wdata;
			end
			// Sample at the end of the access window, while OE is still low
			if (strobeEnd && rd_reg)
				rdata_reg <= flashDqIn;
		end
	end

	// Data is driven one cycle before and after WE so setup and hold are met
	assign flashCeN = (state_reg == C_IDLE);
	assign flashWeN = !(state_reg == C_STROBE && !rd_reg);
	assign flashOeN = !(state_reg == C_STROBE && rd_reg);
	assign flashDqOe = (state_reg != C_IDLE) && !rd_reg;
	assign flashAddr = addr_reg;
	assign flashDqOut = wdata_reg;
	assign done = (state_reg == C_HOLD);
	assign rdata = rdata_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence sWrStart;
		state_reg == C_IDLE && start && !isRead;
	endsequence
	sequence sRdStart;
		state_reg == C_IDLE && start && isRead;
	endsequence

	writeShape_a: assert property (@(posedge mclk) disable iff (rst)
		sWrStart |=> (!flashCeN && flashWeN && flashDqOe) ##1 (!flashWeN && flashDqOe)
			##1 (flashWeN && flashDqOe && done))
		else $error("write cycle shape wrong");

	readShape_a: assert property (@(posedge mclk) disable iff (rst)
		sRdStart |=> (!flashCeN && flashOeN && !flashDqOe) ##1 (!flashOeN && !flashCeN)[*3]
			##1 (flashOeN && done && !flashDqOe))
		else $error("read cycle shape wrong");

endmodule // fbp_bus_cycle
`default_nettype wire

// *** core/fbp_host.sv ***
// Overview of operation
// - Enter modes with unlock prefix then code
// - Mode held until matching exit command
// - Status reads are plain CE/OE reads
// - Password moved as four 16-bit quarters
// - Unlock commands spaced six microseconds apart
`timescale 1ns/1ps
`default_nettype none
module fbp_host
	import fbp_pkg::*;
(
	// System
	input wire logic mclk,
	input wire logic rst,
	// Command port
	input wire logic cmdValid,
	output logic cmdReady,
	input wire fbp_op_t cmdOp,
	input wire logic [ADDR_W-1:0] cmdAddr,
	input wire logic [DATA_W-1:0] cmdData,
	input wire logic [PWD_W-1:0] cmdPwd,
	// Response port
	output logic rspValid,
	output logic rspErr,
	output logic [PWD_W-1:0] rspData,
	output logic [7:0] curMode,
	// Flash pins
	output logic flashCeN,
	output logic flashOeN,
	output logic flashWeN,
	output logic [ADDR_W-1:0] flashAddr,
	output logic [DATA_W-1:0] flashDqOut,
	output logic flashDqOe,
	input wire logic [DATA_W-1:0] flashDqIn
);

	// ------------------------------------------------------------
	// Bus cycle table
	// ------------------------------------------------------------
	function automatic logic [2:0] lastStepOf(input fbp_op_t op, input logic ext);
		case (op)
			OP_ENTER: lastStepOf = 3'd2;
			OP_EXIT: lastStepOf = ext ? 3'd3 : 3'd1;
			OP_READ: lastStepOf = 3'd0;
			OP_PROG, OP_PROTECT, OP_UNPROTECT: lastStepOf = ext ? 3'd3 : 3'd1;
			OP_CLEAR_ALL: lastStepOf = 3'd1;
			OP_UNLOCK: lastStepOf = 3'd6;
			OP_READ_PWD: lastStepOf = 3'd3;
			default: lastStepOf = 3'd0;
		endcase
	endfunction

	// Returns {isRead, address, data} for one step of a command
	function automatic logic [ADDR_W+DATA_W:0] stepOf(input fbp_op_t op, input logic ext,
		input logic [2:0] step, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [PWD_W-1:0] pwd);
		logic [DATA_W-1:0] payload;
		logic [1:0] q;
		payload = (op == OP_PROTECT) ? PROT_ON : (op == OP_UNPROTECT) ? PROT_OFF : d;
		q = 2'(step - 3'd2);
		stepOf = {1'b0, ADDR_ANY, 16'h0000};
		case (op)
			OP_ENTER, OP_EXIT, OP_PROG, OP_PROTECT, OP_UNPROTECT: begin
				// Extended-mode program and exit carry the full unlock prefix
				if (op == OP_ENTER || ext) begin
					case (step)
						3'd0: stepOf = {1'b0, ADDR_UNLOCK1, 8'h00, CODE_AA};
						3'd1: stepOf = {1'b0, ADDR_UNLOCK2, 8'h00, CODE_55};
						3'd2: stepOf = {1'b0, ADDR_UNLOCK1, 8'h00,
							(op == OP_ENTER) ? d[7:0] : (op == OP_EXIT) ? CODE_EXIT1 : CODE_PROG};
						default: stepOf = (op == OP_EXIT) ? {1'b0, ADDR_ANY, 8'h00, CODE_EXIT2}
							: {1'b0, a, payload};
					endcase
				end else if (op == OP_EXIT) begin
					stepOf = {1'b0, ADDR_ANY, 8'h00, (step == 3'd0) ? CODE_EXIT1 : CODE_EXIT2};
				end else begin
					stepOf = (step == 3'd0) ? {1'b0, ADDR_ANY, 8'h00, CODE_PROG}
						: {1'b0, a, payload};
				end
			end
			OP_READ: stepOf = {1'b1, a, 16'h0000};
			OP_CLEAR_ALL: stepOf = {1'b0, ADDR_ANY, 8'h00,
				(step == 3'd0) ? CODE_CLR1 : CODE_CLR2};
			OP_UNLOCK: begin
				case (step)
					3'd0: stepOf = {1'b0, ADDR_ANY, 8'h00, CODE_UNL1};
					3'd1: stepOf = {1'b0, ADDR_ANY, 8'h00, CODE_UNL2};
					3'd6: stepOf = {1'b0, ADDR_ANY, 8'h00, CODE_UNL3};
					default: stepOf = {1'b0, 24'h000000, q, pwd[q*16 +: 16]};
				endcase
			end
			OP_READ_PWD: stepOf = {1'b1, 24'h000000, step[1:0], 16'h0000};
			default: stepOf = {1'b0, ADDR_ANY, 16'h0000};
		endcase
	endfunction

	// ------------------------------------------------------------
	// Command acceptance
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_ISSUE = 2'b01,
		S_WAIT = 2'b10
	} fbp_state_t;

	fbp_state_t state_reg;
	fbp_op_t op_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] data_reg;
	logic [PWD_W-1:0] pwd_reg;
	logic [2:0] step_reg;
	logic [7:0] mode_reg;
	logic [7:0] timer_reg;
	logic nvLocked_reg;
	logic extLocked_reg;
	logic rspValid_reg;
	logic rspErr_reg;
	logic [PWD_W-1:0] rspData_reg;

	wire logic inProt = mode_reg inside {MODE_LOCKREG, MODE_PWD, MODE_NV, MODE_LOCKBIT, MODE_VOL};
	wire logic inExt = (mode_reg == MODE_EXT);
	wire logic knownMode = cmdData[7:0] inside {MODE_LOCKREG, MODE_PWD, MODE_NV,
		MODE_LOCKBIT, MODE_VOL, MODE_EXT};
	wire logic cmdBlock0 = (cmdAddr[ADDR_W-1:BLOCK_LSB] == '0);

	// No read/reset or erase command is offered, so none can reach the part in a mode
	// that ignores or rejects it
	wire logic cmdLegal =
		(cmdOp == OP_ENTER) ? (mode_reg == MODE_READ && knownMode) :
		(cmdOp == OP_EXIT) ? (mode_reg != MODE_READ) :
		(cmdOp == OP_READ) ? !(inProt && cmdBlock0) :
		(cmdOp == OP_PROG) ? (mode_reg inside {MODE_LOCKREG, MODE_PWD}
			|| (inExt && !extLocked_reg)) :
		(cmdOp == OP_PROTECT) ? ((mode_reg == MODE_NV && !nvLocked_reg)
			|| mode_reg inside {MODE_VOL, MODE_LOCKBIT}) :
		(cmdOp == OP_UNPROTECT) ? (mode_reg == MODE_VOL) :
		(cmdOp == OP_CLEAR_ALL) ? (mode_reg == MODE_NV && !nvLocked_reg) :
		(cmdOp == OP_UNLOCK || cmdOp == OP_READ_PWD) ? (mode_reg == MODE_PWD) : 1'b0;

	// The unlock spacing also holds off every other command until the unlock settles
	assign cmdReady = (state_reg == S_IDLE) && (timer_reg == 8'h00);
	wire logic accept = cmdValid && cmdReady;

	// ------------------------------------------------------------
	// Step sequencing
	// ------------------------------------------------------------
	wire logic [ADDR_W+DATA_W:0] stepWord = stepOf(op_reg, inExt, step_reg, addr_reg,
		data_reg, pwd_reg);
	wire logic stepRd = stepWord[ADDR_W+DATA_W];
	wire logic [ADDR_W-1:0] stepAddr = stepWord[ADDR_W+DATA_W-1:DATA_W];
	wire logic [DATA_W-1:0] stepData = stepWord[DATA_W-1:0];
	wire logic cycDone;
	wire logic [DATA_W-1:0] cycRdata;
	wire logic isLast = (step_reg == lastStepOf(op_reg, inExt));
	wire logic finish = (state_reg == S_WAIT) && cycDone && isLast;

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= S_IDLE;
			step_reg <= 3'd0;
		end else begin
			case (state_reg)
				S_IDLE: state_reg <= (accept && cmdLegal) ? S_ISSUE : S_IDLE;
				S_ISSUE: state_reg <= S_WAIT;
				S_WAIT: state_reg <= cycDone ? (isLast ? S_IDLE : S_ISSUE) : S_WAIT;
				default: state_reg <= S_IDLE;
			endcase
			if (state_reg == S_IDLE)
				step_reg <= 3'd0;
			else if (state_reg == S_WAIT && cycDone)
				step_reg <= step_reg + 3'd1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			op_reg <= OP_READ;
			addr_reg <= '0;
			data_reg <= '0;
			pwd_reg <= '0;
		end else if (accept) begin
			op_reg <= cmdOp;
			addr_reg <= cmdAddr;
			data_reg <= cmdData;
			pwd_reg <= cmdPwd;
		end
	end

	// ------------------------------------------------------------
	// Mode and lock tracking
	// ------------------------------------------------------------
	// The wrong-password case is invisible on the bus, so the guard copy is an optimistic
	// mirror; the part itself refuses anything the real lock forbids
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_reg <= MODE_READ;
			nvLocked_reg <= 1'b0;
			extLocked_reg <= 1'b0;
			timer_reg <= 8'h00;
		end else begin
			if (finish && op_reg == OP_ENTER)
				mode_reg <= data_reg[7:0];
			else if (finish && op_reg == OP_EXIT)
				mode_reg <= MODE_READ;
			if (finish && op_reg == OP_PROTECT && mode_reg == MODE_LOCKBIT)
				nvLocked_reg <= 1'b1;
			else if (finish && op_reg == OP_UNLOCK)
				nvLocked_reg <= 1'b0;
			if (finish && op_reg == OP_PROG && mode_reg == MODE_LOCKREG && !data_reg[0])
				extLocked_reg <= 1'b1;
			if (finish && op_reg == OP_UNLOCK)
				timer_reg <= 8'(PWD_DELAY_CYC);
			else if (timer_reg != 8'h00)
				timer_reg <= timer_reg - 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Response
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			rspValid_reg <= 1'b0;
			rspErr_reg <= 1'b0;
			rspData_reg <= '0;
		end else begin
			rspValid_reg <= finish || (accept && !cmdLegal);
			rspErr_reg <= accept && !cmdLegal;
			if (accept)
				rspData_reg <= '0;
			else if (state_reg == S_WAIT && cycDone && stepRd)
				rspData_reg[step_reg[1:0]*16 +: 16] <= cycRdata;
		end
	end

	assign rspValid = rspValid_reg;
	assign rspErr = rspErr_reg;
	assign rspData = rspData_reg;
	assign curMode = mode_reg;

	fbp_bus_cycle #(.WE_CYCLES(WE_CYC), .RD_CYCLES(RD_CYC)) u_cycle (
		.mclk(mclk), .rst(rst), .start(state_reg == S_ISSUE), .isRead(stepRd),
		.addr(stepAddr), .wdata(stepData), .done(cycDone), .rdata(cycRdata),
		.flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
		.flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
		.flashDqIn(flashDqIn));

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	localparam int UNL_GAP = PWD_DELAY_CYC;
	spacingGate_a: assert property (@(posedge mclk) disable iff (rst)
		(finish && op_reg == OP_UNLOCK) |=> !cmdReady ##UNL_GAP cmdReady)
		else $error("unlock spacing not kept");
	unlockDelay_a: assert property (@(posedge mclk) disable iff (rst)
		(finish && op_reg == OP_UNLOCK) |=> (timer_reg == 8'(PWD_DELAY_CYC)) ##1 !cmdReady)
		else $error("unlock delay not started");
	exitMode_a: assert property (@(posedge mclk) disable iff (rst)
		(finish && op_reg == OP_EXIT) |=> (curMode == MODE_READ) && rspValid && !rspErr)
		else $error("exit did not return to read mode");
	enterMode_a: assert property (@(posedge mclk) disable iff (rst)
		(state_reg == S_ISSUE && op_reg == OP_ENTER && step_reg == 3'd0)
			|-> stepAddr == ADDR_UNLOCK1 && stepData == {8'h00, CODE_AA})
		else $error("mode entry does not start with unlock prefix");
	blockZero_a: assert property (@(posedge mclk) disable iff (rst)
		(accept && cmdOp == OP_READ && inProt && cmdBlock0) |=> rspValid && rspErr)
		else $error("block 0 read allowed in protection mode");
	upperByte_a: assert property (@(posedge mclk) disable iff (rst)
		(state_reg == S_ISSUE && op_reg inside {OP_ENTER, OP_EXIT, OP_CLEAR_ALL})
			|-> stepData[15:8] == 8'h00)
		else $error("upper byte not zero in command cycle");
	clearLocked_a: assert property (@(posedge mclk) disable iff (rst)
		(accept && cmdOp == OP_CLEAR_ALL && nvLocked_reg) |=> rspErr ##1 (state_reg == S_IDLE))
		else $error("clear-all issued while guard locked");
	pwdAddr_a: assert property (@(posedge mclk) disable iff (rst)
		(state_reg == S_ISSUE && op_reg == OP_READ_PWD) |-> stepAddr == ADDR_W'(step_reg))
		else $error("password quarter address wrong");
	extSealed_a: assert property (@(posedge mclk) disable iff (rst)
		(accept && cmdOp == OP_PROG && inExt && extLocked_reg) |=> rspErr)
		else $error("program sent to sealed extended block");
	protCode_a: assert property (@(posedge mclk) disable iff (rst)
		(state_reg == S_ISSUE && op_reg == OP_UNPROTECT && step_reg == 3'd1 && !inExt)
			|-> stepData == PROT_OFF)
		else $error("unprotect code wrong");

endmodule // fbp_host
`default_nettype wire

// *** tb/fbp_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_model
	import fbp_pkg::*;
#(
	parameter int PWD_LOCK_BIT = 2
) (
	// Power and reset
	input wire logic hwRst,
	// Flash pins
	input wire logic ceN,
	input wire logic oeN,
	input wire logic weN,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] dqOut,
	input wire logic dqOe,
	output logic [DATA_W-1:0] dqIn
);
	logic [7:0] mode = MODE_READ;
	logic [7:0] pend = 8'h00;
	logic [1:0] pfx = 2'h0;
	logic [2:0] nWr = 3'h0;
	logic [15:0] pwd [4] = '{default: 16'hFFFF};
	logic [15:0] ext [8] = '{default: 16'hFFFF};
	logic [15:0] lockReg = 16'hFFFF;
	logic [15:0] nv = 16'hFFFF;
	logic [15:0] vol = 16'hFFFF;
	logic guard = 1'b1;
	logic [63:0] tryPwd = 64'h0;
	logic [15:0] rdVal;
	logic [15:0] lastVal = 16'h0000;
	realtime lastUnl = -1.0e6;
	wire [3:0] blk = addr[19:16];
	wire [7:0] d8 = dqOut[7:0];
	// Password words sit at the bottom addresses, so password mode must not hide them
	wire blocked = addr[25:16] == 10'h000
		&& mode inside {MODE_LOCKREG, MODE_NV, MODE_LOCKBIT, MODE_VOL};
	wire drv = !ceN && !oeN && !blocked;

	function automatic logic [15:0] arr(input logic [ADDR_W-1:0] a);
		return a[15:0] ^ 16'h5A3C;
	endfunction

	// ------------------------------------------------------------
	// Command decoding on the closing edge of each write strobe
	// ------------------------------------------------------------
	task automatic finish();
		case (pend)
			CODE_EXIT1: if (d8 == CODE_EXIT2) mode = MODE_READ;
			CODE_PROG: case (mode)
				MODE_LOCKREG: lockReg = lockReg & dqOut;
				MODE_PWD: pwd[addr[1:0]] = dqOut;
				MODE_NV: if (guard) nv[blk] = 1'b0;
				MODE_LOCKBIT: guard = 1'b0;
				MODE_VOL: vol[blk] = dqOut[0];
				MODE_EXT: if (lockReg[0]) ext[addr[2:0]] = ext[addr[2:0]] & dqOut;
				default: ;
			endcase
			CODE_CLR1: if (d8 == CODE_CLR2 && guard && mode == MODE_NV) begin
				// Program everything first so no bit is erased twice
				nv = 16'h0000;
				nv = 16'hFFFF;
			end
			default: ;
		endcase
		pend = 8'h00;
	endtask

	task automatic unlockStep();
		if (nWr == 3'h0 && d8 != CODE_UNL2) pend = 8'h00;
		else if (nWr >= 3'h1 && nWr <= 3'h4) tryPwd[16*(nWr-1) +: 16] = dqOut;
		else if (nWr == 3'h5) begin
			// A too early retry is dropped even when the value is right
			if (d8 == CODE_UNL3 && $realtime - lastUnl >= 6000.0
					&& tryPwd == {pwd[3], pwd[2], pwd[1], pwd[0]})
				guard <= #6000 1'b1;
			lastUnl = $realtime;
			pend = 8'h00;
		end
		nWr = (pend == 8'h00) ? 3'h0 : nWr + 3'h1;
	endtask

	always @(posedge weN or posedge hwRst) begin
		if (hwRst) begin
			mode = MODE_READ;
			pend = 8'h00;
			pfx = 2'h0;
		end else if (!ceN) begin
			if (pend == CODE_UNL1) unlockStep();
			else if (pend != 8'h00) finish();
			else if (pfx == 2'h0 && addr[15:0] == 16'h0555 && d8 == CODE_AA) pfx = 2'h1;
			else if (pfx == 2'h1 && addr[15:0] == 16'h02AA && d8 == CODE_55) pfx = 2'h2;
			else if (pfx == 2'h2) begin
				pfx = 2'h0;
				if (mode == MODE_READ) mode = d8;
				else pend = d8;
			end else if (mode != MODE_READ && mode != MODE_EXT && d8 != 8'hF0) pend = d8;
			else pfx = 2'h0;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always @* begin
		case (mode)
			MODE_LOCKREG: rdVal = lockReg;
			MODE_PWD: rdVal = lockReg[PWD_LOCK_BIT] ? pwd[addr[1:0]] : 16'h0000;
			MODE_NV: rdVal = {15'h0000, nv[blk]};
			MODE_LOCKBIT: rdVal = {15'h0000, guard};
			MODE_VOL: rdVal = {15'h0000, vol[blk]};
			MODE_EXT: rdVal = (addr[25:16] == 10'h000) ? ext[addr[2:0]] : arr(addr);
			default: rdVal = arr(addr);
		endcase
	end

	// An undriven bus shows the inverse of the last word, never a stale copy
	always @* if (drv) lastVal = rdVal;
	assign dqIn = dqOe ? dqOut : (drv ? rdVal : ~lastVal);
endmodule // fbp_flash_model
`default_nettype wire

// *** tb/fbp_host_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbp_host_bench
	import fbp_pkg::*;
;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cmdValid = 1'b0;
	fbp_op_t cmdOp = OP_ENTER;
	logic [ADDR_W-1:0] cmdAddr = '0;
	logic [DATA_W-1:0] cmdData = '0;
	logic [PWD_W-1:0] cmdPwd = '0;
	logic cmdReady, rspValid, rspErr, ceN, oeN, weN, dqOe;
	logic [PWD_W-1:0] rspData;
	logic [7:0] curMode;
	logic [ADDR_W-1:0] fAddr, a, a2;
	logic [DATA_W-1:0] dqOut, dqIn, d;
	logic [64:0] expQ [$];
	logic [64:0] e;
	logic [31:0] seed = 32'h058B6EC8;
	logic [63:0] pw;
	logic [7:0] modes [5] = '{MODE_LOCKREG, MODE_PWD, MODE_NV, MODE_LOCKBIT, MODE_VOL};
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;

	always #25 mclk = ~mclk;

	fbp_host DUT (.mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdPwd(cmdPwd),
		.rspValid(rspValid), .rspErr(rspErr), .rspData(rspData), .curMode(curMode),
		.flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN), .flashAddr(fAddr),
		.flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dqIn));

	fbp_flash_model flash (.hwRst(rst), .ceN(ceN), .oeN(oeN), .weN(weN), .addr(fAddr),
		.dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [63:0] arr(input logic [ADDR_W-1:0] x);
		return {48'h0, x[15:0] ^ 16'h5A3C};
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// One command at a time; the answer is noted before the request goes out
	task automatic c(input fbp_op_t op, input logic [ADDR_W-1:0] ad, input logic [15:0] dd,
			input logic [63:0] p, input logic er, input logic [63:0] x);
		logic r;
		cmdValid <= 1'b1;
		cmdOp <= op;
		cmdAddr <= ad;
		cmdData <= dd;
		cmdPwd <= p;
		expQ.push_back({er, x});
		do begin
			@(negedge mclk);
			r = cmdReady;
			@(posedge mclk);
		end while (r !== 1'b1);
		cmdValid <= 1'b0;
		while (expQ.size() != 0) @(posedge mclk);
	endtask

	always @(negedge mclk) if (rspValid === 1'b1) begin
		if (expQ.size() == 0) check(64'h1, 64'h0);
		else begin
			e = expQ.pop_front();
			check(64'(rspErr), 64'(e[64]));
			check(rspData, e[63:0]);
		end
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			end_sim();
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 4; i++) begin
			a = ADDR_W'(rnd());
			c(OP_READ, a, '0, '0, 1'b0, arr(a));
		end
		c(OP_EXIT, '0, '0, '0, 1'b1, '0);
		c(OP_ENTER, '0, 16'h0077, '0, 1'b1, '0);
		foreach (modes[i]) begin
			c(OP_ENTER, '0, {8'h00, modes[i]}, '0, 1'b0, '0);
			check(64'(curMode), 64'(modes[i]));
			c(OP_ENTER, '0, 16'h0040, '0, 1'b1, '0);
			c(OP_READ, 26'h0000123, '0, '0, 1'b1, '0);
			c(OP_EXIT, '0, '0, '0, 1'b0, '0);
			check(64'(curMode), 64'(MODE_READ));
		end
		a = {6'h00, 4'(rnd() % 15 + 1), 16'(rnd())};
		c(OP_ENTER, '0, 16'h00C0, '0, 1'b0, '0);
		c(OP_READ, a, '0, '0, 1'b0, 64'h1);
		c(OP_PROTECT, a, '0, '0, 1'b0, '0);
		c(OP_READ, a, '0, '0, 1'b0, 64'h0);
		c(OP_UNPROTECT, a, '0, '0, 1'b1, '0);
		c(OP_CLEAR_ALL, '0, '0, '0, 1'b0, '0);
		c(OP_READ, a, '0, '0, 1'b0, 64'h1);
		c(OP_PROTECT, a, '0, '0, 1'b0, '0);
		c(OP_EXIT, '0, '0, '0, 1'b0, '0);
		c(OP_ENTER, '0, 16'h00E0, '0, 1'b0, '0);
		c(OP_READ, a, '0, '0, 1'b0, 64'h1);
		c(OP_PROTECT, a, '0, '0, 1'b0, '0);
		c(OP_READ, a, '0, '0, 1'b0, 64'h0);
		c(OP_UNPROTECT, a, '0, '0, 1'b0, '0);
		c(OP_READ, a, '0, '0, 1'b0, 64'h1);
		c(OP_CLEAR_ALL, '0, '0, '0, 1'b1, '0);
		c(OP_EXIT, '0, '0, '0, 1'b0, '0);
		c(OP_ENTER, '0, 16'h0060, '0, 1'b0, '0);
		c(OP_READ_PWD, '0, '0, '0, 1'b0, 64'hFFFF_FFFF_FFFF_FFFF);
		pw = {rnd(), rnd()};
		for (int q = 0; q < 4; q++) c(OP_PROG, ADDR_W'(q), pw[16*q +: 16], '0, 1'b0, '0);
		c(OP_READ_PWD, '0, '0, '0, 1'b0, pw);
		c(OP_EXIT, '0, '0, '0, 1'b0, '0);
		c(OP_ENTER, '0, 16'h0050, '0, 1'b0, '0);
		c(OP_READ, a, '0, '0, 1'b0, 64'h1);
		c(OP_PROTECT, '0, '0, '0, 1'b0, '0);
		c(OP_READ, a, '0, '0, 1'b0, 64'h0);
		c(OP_EXIT, '0, '0, '0, 1'b0, '0);
		c(OP_ENTER, '0, 16'h00C0, '0, 1'b0, '0);
		c(OP_CLEAR_ALL, '0, '0, '0, 1'b1, '0);
		c(OP_PROTECT, a, '0, '0, 1'b1, '0);
		c(OP_EXIT, '0, '0, '0, 1'b0, '0);
		for (int k = 0; k < 2; k++) begin
			c(OP_ENTER, '0, 16'h0060, '0, 1'b0, '0);
			c(OP_UNLOCK, '0, '0, (k == 0) ? ~pw : pw, 1'b0, '0);
			n = 0;
			while (cmdReady !== 1'b1 && n < 500) begin
				@(posedge mclk);
				n++;
			end
			check(64'(n >= PWD_DELAY_CYC - 2), 64'h1);
			c(OP_EXIT, '0, '0, '0, 1'b0, '0);
			c(OP_ENTER, '0, 16'h0050, '0, 1'b0, '0);
			c(OP_READ, a, '0, '0, 1'b0, 64'(k));
			c(OP_EXIT, '0, '0, '0, 1'b0, '0);
		end
		a2 = {23'h0, 3'(rnd())};
		d = 16'(rnd());
		c(OP_ENTER, '0, 16'h0088, '0, 1'b0, '0);
		c(OP_PROG, a2, d, '0, 1'b0, '0);
		c(OP_PROG, a2, 16'hFFFF, '0, 1'b0, '0);
		c(OP_READ, a2, '0, '0, 1'b0, {48'h0, d});
		c(OP_EXIT, '0, '0, '0, 1'b0, '0);
		c(OP_READ, a2, '0, '0, 1'b0, arr(a2));
		c(OP_ENTER, '0, 16'h0040, '0, 1'b0, '0);
		c(OP_READ, 26'h0010000, '0, '0, 1'b0, 64'hFFFF);
		c(OP_PROG, '0, 16'hFFFE, '0, 1'b0, '0);
		c(OP_READ, 26'h0010000, '0, '0, 1'b0, 64'hFFFE);
		c(OP_PROG, '0, 16'hFFFB, '0, 1'b0, '0);
		c(OP_READ, 26'h0010000, '0, '0, 1'b0, 64'hFFFA);
		c(OP_EXIT, '0, '0, '0, 1'b0, '0);
		c(OP_ENTER, '0, 16'h0060, '0, 1'b0, '0);
		c(OP_READ_PWD, '0, '0, '0, 1'b0, 64'h0);
		c(OP_EXIT, '0, '0, '0, 1'b0, '0);
		c(OP_ENTER, '0, 16'h0088, '0, 1'b0, '0);
		c(OP_PROG, a2, 16'h0000, '0, 1'b1, '0);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		check(64'(curMode), 64'(MODE_READ));
		c(OP_READ, a2, '0, '0, 1'b0, arr(a2));
		end_sim();
	end
endmodule // fbp_host_bench
`default_nettype wire
